// ---- hw/ptm_params.svh ----
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH

// Register byte offsets
`define PTM_OFF_CTRL0      8'h00
`define PTM_OFF_CTRL1      8'h04
`define PTM_OFF_CNT_LO     8'h08
`define PTM_OFF_CNT_HI     8'h0C
`define PTM_OFF_DUTY_LO    8'h10
`define PTM_OFF_DUTY_HI    8'h14
`define PTM_OFF_PER_LO     8'h18
`define PTM_OFF_PER_HI     8'h1C
`define PTM_OFF_FLAGS      8'h20

// First control register fields
`define PTM_C0_PAUSE       7
`define PTM_C0_CKSEL_HI    6
`define PTM_C0_CKSEL_LO    4
`define PTM_C0_ON          3
`define PTM_C0_MASK        8'hF8

// Second control register fields
`define PTM_C1_MODE_HI     7
`define PTM_C1_MODE_LO     6
`define PTM_C1_IO_HI       5
`define PTM_C1_IO_LO       4
`define PTM_C1_OC          3
`define PTM_C1_POL         2
`define PTM_C1_RSVD        1
`define PTM_C1_CCLR        0

// Flag register fields
`define PTM_FL_DUTY        0
`define PTM_FL_PER         1

`define PTM_RST_BYTE       8'h00
`define PTM_PRE_W          6

`endif

// ---- hw/ptm_pkg.sv ----
package ptm_pkg;

	typedef enum logic [1:0] {
		PTM_MODE_CMP   = 2'b00,
		PTM_MODE_UNDEF = 2'b01,
		PTM_MODE_PULSE = 2'b10,
		PTM_MODE_TIMER = 2'b11
	} ptm_mode_t;

	typedef enum logic [2:0] {
		PTM_CK_SYS4   = 3'b000,
		PTM_CK_SYS    = 3'b001,
		PTM_CK_HI16   = 3'b010,
		PTM_CK_HI64   = 3'b011,
		PTM_CK_SUB0   = 3'b100,
		PTM_CK_SUB1   = 3'b101,
		PTM_CK_EXTR   = 3'b110,
		PTM_CK_EXTF   = 3'b111
	} ptm_cksel_t;

	typedef enum logic [1:0] {
		PTM_IO_00 = 2'b00,
		PTM_IO_01 = 2'b01,
		PTM_IO_10 = 2'b10,
		PTM_IO_11 = 2'b11
	} ptm_io_t;

endpackage

// ---- hw/ptm_timer.sv ----
`timescale 1ns/1ps
`include "ptm_params.svh"

module ptm_timer #(
	parameter int WIDTH = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sub_clock_tick,
	input wire logic external_clock_pin,
	output logic timer_output_pin,
	output logic timer_output_pin_oe,
	output logic duty_match_flag,
	output logic period_match_flag
);
	import ptm_pkg::*;

	if (WIDTH != 10 && WIDTH != 16) begin : g_width_check
		$error("ptm_timer: WIDTH must be 10 or 16");
	end

	function automatic logic addr_known(input logic [7:0] a);
		case (a)
			`PTM_OFF_CTRL0, `PTM_OFF_CTRL1, `PTM_OFF_CNT_LO, `PTM_OFF_CNT_HI,
			`PTM_OFF_DUTY_LO, `PTM_OFF_DUTY_HI, `PTM_OFF_PER_LO, `PTM_OFF_PER_HI,
			`PTM_OFF_FLAGS: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction

	logic [7:0] ctrl0, next_ctrl0;
	logic [7:0] ctrl1, next_ctrl1;
	logic [WIDTH-1:0] cnt, next_cnt;
	logic [WIDTH-1:0] duty, next_duty;
	logic [WIDTH-1:0] period, next_period;
	logic [`PTM_PRE_W-1:0] pre, next_pre;
	logic on_q, next_on_q;
	logic ext_q, next_ext_q;
	logic out_lvl, next_out_lvl;
	logic next_pin, next_pin_oe;
	logic next_duty_flag, next_per_flag;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	ptm_mode_t mode;
	ptm_cksel_t cksel;
	ptm_io_t io;
	logic pause, on, oc, pol, cclr;
	logic tick, ext_rise, ext_fall, ext_trig, on_rise, run;
	logic [WIDTH-1:0] cnt_inc;
	logic duty_hit, per_hit, oneshot, clr;
	logic access, we, hit;
	logic [15:0] cnt_w, duty_w, per_w;
	logic [7:0] rbyte;

	assign pause = ctrl0[`PTM_C0_PAUSE];
	assign on = ctrl0[`PTM_C0_ON];
	assign cksel = ptm_cksel_t'(ctrl0[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO]);
	assign mode = ptm_mode_t'(ctrl1[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO]);
	assign io = ptm_io_t'(ctrl1[`PTM_C1_IO_HI:`PTM_C1_IO_LO]);
	assign oc = ctrl1[`PTM_C1_OC];
	assign pol = ctrl1[`PTM_C1_POL];
	assign cclr = ctrl1[`PTM_C1_CCLR];
	assign cnt_w = 16'(cnt);
	assign duty_w = 16'(duty);
	assign per_w = 16'(period);

	// Counter clock and match detection
	always_comb begin
		next_pre = pre + {{(`PTM_PRE_W-1){1'b0}}, 1'b1};
		ext_rise = external_clock_pin & ~ext_q;
		ext_fall = ~external_clock_pin & ext_q;
		// The high clock is taken equal to the system clock here
		case (cksel)
			PTM_CK_SYS4: tick = &pre[1:0];
			PTM_CK_SYS: tick = 1'b1;
			PTM_CK_HI16: tick = &pre[3:0];
			PTM_CK_HI64: tick = &pre;
			PTM_CK_SUB0, PTM_CK_SUB1: tick = sub_clock_tick;
			PTM_CK_EXTR: tick = ext_rise;
			PTM_CK_EXTF: tick = ext_fall;
			default: tick = 1'b0;
		endcase
		ext_trig = (cksel == PTM_CK_EXTF) ? ext_fall : ext_rise;
		on_rise = on & ~on_q;
		// A rising on bit restarts instead of counting in the same cycle
		run = on & on_q & ~pause & tick;
		cnt_inc = cnt + {{(WIDTH-1){1'b0}}, 1'b1};
		oneshot = (mode == PTM_MODE_PULSE) && (io == PTM_IO_11);
		// Zero duty never matches, so when the duty match owns the clear the counter wraps past its maximum
		duty_hit = run && (duty != '0) && (cnt_inc == duty);
		per_hit = run && (period != '0) && (cnt_inc == period) && !oneshot;
		if (mode == PTM_MODE_PULSE) begin
			clr = per_hit;
		end else begin
			clr = cclr ? duty_hit : per_hit;
		end
	end

	// Period flag is not raised when the duty match owns the clear
	function automatic logic per_flag_set(input logic ph);
		per_flag_set = ph & ~(cclr & mode != PTM_MODE_PULSE);
	endfunction

	// Counter, flags and on bit
	always_comb begin
		next_on_q = on;
		next_ext_q = external_clock_pin;
		if (on_rise) begin
			next_cnt = '0;
		end else if (run) begin
			next_cnt = clr ? '0 : cnt_inc;
		end else begin
			next_cnt = cnt;
		end
		// Hardware set wins over a write-one-to-clear in the same cycle
		next_duty_flag = duty_hit | duty_match_flag;
		next_per_flag = per_flag_set(per_hit) | period_match_flag;
		if (we && paddr == `PTM_OFF_FLAGS) begin
			if (pwdata[`PTM_FL_DUTY] && !duty_hit) begin
				next_duty_flag = 1'b0;
			end
			if (pwdata[`PTM_FL_PER] && !per_flag_set(per_hit)) begin
				next_per_flag = 1'b0;
			end
		end
	end

	// Register writes
	always_comb begin
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		next_duty = duty;
		next_period = period;
		if (we) begin
			case (paddr)
				`PTM_OFF_CTRL0: next_ctrl0 = pwdata[7:0] & `PTM_C0_MASK;
				`PTM_OFF_CTRL1: next_ctrl1 = pwdata[7:0];
				`PTM_OFF_DUTY_LO: next_duty[7:0] = pwdata[7:0];
				`PTM_OFF_DUTY_HI: next_duty[WIDTH-1:8] = pwdata[WIDTH-9:0];
				`PTM_OFF_PER_LO: next_period[7:0] = pwdata[7:0];
				`PTM_OFF_PER_HI: next_period[WIDTH-1:8] = pwdata[WIDTH-9:0];
				default: next_ctrl0 = ctrl0;
			endcase
		end
		// One-shot: match ends the pulse, pin edge starts it, edge wins
		if (oneshot && duty_hit) begin
			next_ctrl0[`PTM_C0_ON] = 1'b0;
		end
		if (oneshot && ext_trig) begin
			next_ctrl0[`PTM_C0_ON] = 1'b1;
		end
	end

	// Output waveform
	always_comb begin
		next_out_lvl = out_lvl;
		if (mode == PTM_MODE_TIMER || mode == PTM_MODE_UNDEF) begin
			next_out_lvl = out_lvl;
		end else if (on_rise) begin
			next_out_lvl = oc;
		end else if (mode == PTM_MODE_CMP) begin
			if (duty_hit) begin
				// Requesting the present level simply rewrites it
				case (io)
					PTM_IO_01: next_out_lvl = 1'b0;
					PTM_IO_10: next_out_lvl = 1'b1;
					PTM_IO_11: next_out_lvl = ~out_lvl;
					default: next_out_lvl = out_lvl;
				endcase
			end
		end else begin
			case (io)
				PTM_IO_00: next_out_lvl = ~oc;
				PTM_IO_01: next_out_lvl = oc;
				PTM_IO_10: next_out_lvl = (on && cnt < duty) ? oc : ~oc;
				PTM_IO_11: next_out_lvl = on ? oc : ~oc;
				default: next_out_lvl = out_lvl;
			endcase
		end
		next_pin_oe = (mode != PTM_MODE_TIMER);
		next_pin = next_pin_oe & (out_lvl ^ pol);
	end

	// APB slave: one wait state, registered answer
	always_comb begin
		access = psel & penable & ~pready;
		hit = addr_known(paddr);
		we = psel & penable & pready & pwrite & hit;
		case (paddr)
			`PTM_OFF_CTRL0: rbyte = ctrl0;
			`PTM_OFF_CTRL1: rbyte = ctrl1;
			`PTM_OFF_CNT_LO: rbyte = cnt_w[7:0];
			`PTM_OFF_CNT_HI: rbyte = cnt_w[15:8];
			`PTM_OFF_DUTY_LO: rbyte = duty_w[7:0];
			`PTM_OFF_DUTY_HI: rbyte = duty_w[15:8];
			`PTM_OFF_PER_LO: rbyte = per_w[7:0];
			`PTM_OFF_PER_HI: rbyte = per_w[15:8];
			`PTM_OFF_FLAGS: rbyte = {6'h00, period_match_flag, duty_match_flag};
			default: rbyte = 8'h00;
		endcase
		next_pready = access;
		next_pslverr = access & ~hit;
		next_prdata = (access && !pwrite && hit) ? {24'h000000, rbyte} : 32'h00000000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0 <= `PTM_RST_BYTE;
			ctrl1 <= `PTM_RST_BYTE;
			cnt <= '0;
			duty <= '0;
			period <= '0;
			pre <= '0;
			on_q <= 1'b0;
			ext_q <= 1'b0;
			out_lvl <= 1'b0;
			timer_output_pin <= 1'b0;
			timer_output_pin_oe <= 1'b0;
			duty_match_flag <= 1'b0;
			period_match_flag <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl0 <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			cnt <= next_cnt;
			duty <= next_duty;
			period <= next_period;
			pre <= next_pre;
			on_q <= next_on_q;
			ext_q <= next_ext_q;
			out_lvl <= next_out_lvl;
			timer_output_pin <= next_pin;
			timer_output_pin_oe <= next_pin_oe;
			duty_match_flag <= next_duty_flag;
			period_match_flag <= next_per_flag;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_pause_hold;
		(on && on_q && pause) |=> (cnt == $past(cnt));
	endproperty
	a_pause_hold: assert property (p_pause_hold)
		else $error("counter moved while paused");

	property p_start_zero;
		(on && !on_q) |=> (cnt == '0);
	endproperty
	a_start_zero: assert property (p_start_zero)
		else $error("counter not zero after start");

	property p_off_hold;
		(!on && !on_q) |=> $stable(cnt);
	endproperty
	a_off_hold: assert property (p_off_hold)
		else $error("counter moved while off");

	property p_init_level;
		(on && !on_q && mode != PTM_MODE_TIMER && mode != PTM_MODE_UNDEF)
			|=> (out_lvl == $past(oc)) ##1 (timer_output_pin == ($past(oc, 2) ^ $past(pol)));
	endproperty
	a_init_level: assert property (p_init_level)
		else $error("output not at initial level after start");

	property p_period_clear;
		(run && mode == PTM_MODE_CMP && !cclr && period != '0 && cnt + 1'b1 == period)
			|=> (cnt == '0) && period_match_flag;
	endproperty
	a_period_clear: assert property (p_period_clear)
		else $error("period match did not clear counter");

	property p_duty_clear;
		(run && mode == PTM_MODE_CMP && cclr && duty != '0 && cnt + 1'b1 == duty)
			|=> (cnt == '0) && duty_match_flag;
	endproperty
	a_duty_clear: assert property (p_duty_clear)
		else $error("duty match did not clear counter");

	property p_zero_duty;
		(duty == '0 && !duty_match_flag) |=> !duty_match_flag;
	endproperty
	a_zero_duty: assert property (p_zero_duty)
		else $error("duty flag raised with zero duty value");

	property p_oneshot_end;
		(oneshot && duty_hit && !ext_trig) |=> !on ##1 (out_lvl == !$past(oc));
	endproperty
	a_oneshot_end: assert property (p_oneshot_end)
		else $error("one-shot match did not end pulse");

	property p_timer_pin;
		(mode == PTM_MODE_TIMER) |=> !timer_output_pin_oe && !timer_output_pin;
	endproperty
	a_timer_pin: assert property (p_timer_pin)
		else $error("pin driven in timer mode");

	property p_polarity;
		(mode == PTM_MODE_CMP) |=> (timer_output_pin == ($past(out_lvl) ^ $past(pol)));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("pin level does not follow polarity");

endmodule

// ---- test/ptm_pin_partner.sv ----
`timescale 1ns/1ps
module ptm_pin_partner (
	input wire logic pclk,
	output logic external_clock_pin,
	input wire logic timer_output_pin,
	input wire logic timer_output_pin_oe,
	output logic pin_level
);
	// The board pulls the pin down, so a released pin reads low
	assign pin_level = timer_output_pin_oe ? timer_output_pin : 1'b0;
	initial external_clock_pin = 1'b0;
	// Each level is held two cycles so that the edge detector cannot miss it
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			external_clock_pin <= 1'b1;
			repeat (2) @(posedge pclk);
			external_clock_pin <= 1'b0;
			@(posedge pclk);
		end
	endtask
endmodule

// ---- test/ptm_timer_tb.sv ----
`timescale 1ns/1ps
`include "ptm_params.svh"
module ptm_timer_tb;
	import ptm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ext_pin, pin, pin_oe, duty_flag, per_flag, pin_level, rerr;
	logic [7:0] rdat, held;
	int n_errors = 0;
	int num_checks = 0;

	ptm_timer u_ptm_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sub_clock_tick(1'b0), .external_clock_pin(ext_pin),
		.timer_output_pin(pin), .timer_output_pin_oe(pin_oe),
		.duty_match_flag(duty_flag), .period_match_flag(per_flag));
	ptm_pin_partner u_ptm_pin_partner (.pclk(pclk), .external_clock_pin(ext_pin),
		.timer_output_pin(pin), .timer_output_pin_oe(pin_oe), .pin_level(pin_level));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Entered just after a rising edge; one idle edge follows the answer so that
	// a following call never drives psel twice in one time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(name, {24'h0, exp}, {24'h0, rdat});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic test_regs;
		rdc("ctrl0 reset", `PTM_OFF_CTRL0, 8'h00);
		rdc("ctrl1 reset", `PTM_OFF_CTRL1, 8'h00);
		rdc("duty hi reset", `PTM_OFF_DUTY_HI, 8'h00);
		rdc("period lo reset", `PTM_OFF_PER_LO, 8'h00);
		wr(`PTM_OFF_CTRL0, 8'hFF);
		rdc("ctrl0 unused bits", `PTM_OFF_CTRL0, 8'hF8);
		wr(`PTM_OFF_CTRL0, 8'h00);
		wr(`PTM_OFF_DUTY_HI, 8'hFF);
		rdc("duty hi bits", `PTM_OFF_DUTY_HI, 8'h03);
		wr(`PTM_OFF_PER_LO, 8'hA5);
		rdc("period lo", `PTM_OFF_PER_LO, 8'hA5);
		wr(`PTM_OFF_PER_HI, 8'hFF);
		rdc("period hi bits", `PTM_OFF_PER_HI, 8'h03);
		wr(`PTM_OFF_DUTY_HI, 8'h00);
		wr(`PTM_OFF_PER_HI, 8'h00);
		wr(`PTM_OFF_PER_LO, 8'h00);
		apb(1'b0, 8'h24, 8'h00);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		$display("test regs done");
	endtask

	task automatic test_compare;
		wr(`PTM_OFF_DUTY_LO, 8'h05);
		wr(`PTM_OFF_CTRL1, 8'h20);
		wr(`PTM_OFF_CTRL0, 8'h18);
		chk("pin initial low", 32'h0, {31'h0, pin_level});
		idle(20);
		chk("pin set high", 32'h1, {31'h0, pin_level});
		rdc("flags duty only", `PTM_OFF_FLAGS, 8'h01);
		wr(`PTM_OFF_FLAGS, 8'h03);
		wr(`PTM_OFF_CTRL0, 8'h10);
		wr(`PTM_OFF_CTRL1, 8'h24);
		wr(`PTM_OFF_CTRL0, 8'h18);
		idle(2);
		chk("inverted initial", 32'h1, {31'h0, pin_level});
		idle(20);
		chk("inverted match", 32'h0, {31'h0, pin_level});
		wr(`PTM_OFF_CTRL0, 8'h10);
		wr(`PTM_OFF_CTRL1, 8'h10);
		wr(`PTM_OFF_CTRL0, 8'h18);
		idle(20);
		chk("same level no change", 32'h0, {31'h0, pin_level});
		wr(`PTM_OFF_CTRL0, 8'h10);
		wr(`PTM_OFF_CTRL1, 8'h21);
		wr(`PTM_OFF_CTRL0, 8'h18);
		idle(20);
		apb(1'b0, `PTM_OFF_CNT_LO, 8'h00);
		chk("cleared by duty", 32'h1, {31'h0, rdat <= 8'h05});
		$display("test compare done");
	endtask

	task automatic test_period;
		wr(`PTM_OFF_CTRL0, 8'h10);
		wr(`PTM_OFF_CTRL1, 8'h20);
		wr(`PTM_OFF_FLAGS, 8'h03);
		wr(`PTM_OFF_PER_LO, 8'h08);
		wr(`PTM_OFF_CTRL0, 8'h18);
		idle(30);
		apb(1'b0, `PTM_OFF_CNT_LO, 8'h00);
		chk("cleared by period", 32'h1, {31'h0, rdat < 8'h08});
		rdc("flags both", `PTM_OFF_FLAGS, 8'h03);
		wr(`PTM_OFF_CTRL0, 8'h10);
		wr(`PTM_OFF_PER_LO, 8'h00);
		$display("test period done");
	endtask

	task automatic test_count;
		wr(`PTM_OFF_CTRL1, 8'h20);
		wr(`PTM_OFF_CTRL0, 8'h98);
		apb(1'b0, `PTM_OFF_CNT_LO, 8'h00);
		held = rdat;
		idle(6);
		rdc("paused count", `PTM_OFF_CNT_LO, held);
		wr(`PTM_OFF_CTRL0, 8'h18);
		idle(3);
		apb(1'b0, `PTM_OFF_CNT_LO, 8'h00);
		chk("resumed count", 32'h1, {31'h0, rdat > held});
		wr(`PTM_OFF_CTRL0, 8'h10);
		apb(1'b0, `PTM_OFF_CNT_LO, 8'h00);
		held = rdat;
		idle(6);
		rdc("off count held", `PTM_OFF_CNT_LO, held);
		wr(`PTM_OFF_CTRL0, 8'h08);
		idle(40);
		apb(1'b0, `PTM_OFF_CNT_LO, 8'h00);
		chk("quarter rate", 32'h1, {31'h0, rdat >= 8'h09 && rdat <= 8'h0E});
		wr(`PTM_OFF_CTRL0, 8'h00);
		$display("test count done");
	endtask

	task automatic test_oneshot;
		// System clock: a pin clock would retrigger on the edge that matches
		wr(`PTM_OFF_DUTY_LO, 8'h40);
		wr(`PTM_OFF_CTRL1, 8'hB8);
		wr(`PTM_OFF_CTRL0, 8'h10);
		idle(2);
		chk("shot idle", 32'h0, {31'h0, pin_level});
		u_ptm_pin_partner.pulses(1);
		idle(3);
		rdc("shot on set", `PTM_OFF_CTRL0, 8'h18);
		chk("shot active", 32'h1, {31'h0, pin_level});
		idle(80);
		rdc("shot on cleared", `PTM_OFF_CTRL0, 8'h10);
		chk("shot ended", 32'h0, {31'h0, pin_level});
		wr(`PTM_OFF_CTRL1, 8'hC0);
		idle(2);
		chk("timer mode released", 32'h0, {31'h0, pin_oe});
		$display("test oneshot done");
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// The tests need well under 2000 cycles
	initial begin
		idle(20000);
		n_errors++;
		finish_test;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		idle(12);
		presetn <= 1'b1;
		idle(1);
		test_regs;
		test_compare;
		test_period;
		test_count;
		test_oneshot;
		finish_test;
	end
endmodule
